/* File: inc/lvc_pkg.sv */
// Package: constants and carriers for the low-voltage detect control block
package lvc_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [31:0] LVC_CTRL_OFS = 32'h0000_0000;
  localparam logic [31:0] LVC_STAT_OFS = 32'h0000_0004;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int LVC_DET_EN_BIT  = 7;
  localparam int LVC_REF_EN_BIT  = 6;
  localparam int LVC_INT_SEL_BIT = 5;
  localparam int LVC_RSVD_BIT    = 4;
  localparam int LVC_LVL_SEL_BIT = 3;
  localparam int LVC_UVR_EN_BIT  = 2;
  localparam int LVC_FALL_EN_BIT = 1;
  localparam int LVC_RISE_EN_BIT = 0;
  localparam int LVC_FALL_FL_BIT = 1;
  localparam int LVC_RISE_FL_BIT = 0;

  // ----------------------------------------------------------------
  // Reset values, masks and response codes
  // ----------------------------------------------------------------
  localparam logic [7:0] LVC_CTRL_RST  = 8'hF4;
  localparam logic [7:0] LVC_CTRL_KEEP = 8'hEC;
  localparam logic [7:0] LVC_CTRL_ONE  = 8'h10;
  localparam logic [5:0] LVC_STAT_RSVD = 6'h3F;
  localparam logic [1:0] LVC_OKAY      = 2'h0;
  localparam logic [1:0] LVC_SLVERR    = 2'h2;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } lvc_axil_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } lvc_axil_rsp_t;

  // Comparator levels: below_fall, above_rise, below_reset
  typedef struct packed {
    logic below_fall;
    logic above_rise;
    logic below_reset;
  } lvc_sense_t;

  typedef struct packed {
    logic detector_enable;
    logic reference_enable;
    logic internal_compare_select;
    logic reset_level_select;
    logic undervoltage_reset_enable;
    logic fall_irq_enable;
    logic rise_irq_enable;
  } lvc_ctrl_out_t;

endpackage

/* File: rtl/lvc_ctrl.sv */
// Design: low-voltage detect control register, status flags and AXI4-Lite slave
`timescale 1ns/1ps

module lvc_ctrl
  import lvc_pkg::*;
(
  input  wire logic          i_core_clk,
  input  wire logic          i_rst_b,
  input  wire logic          i_clk_en,
  input  wire logic          i_uv_reset,
  input  wire lvc_sense_t    i_sense,
  input  wire lvc_axil_req_t i_axil,
  output lvc_axil_rsp_t      o_axil,
  output lvc_ctrl_out_t      o_ctrl,
  output logic               o_uv_reset_req,
  output logic               o_irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  ctrl;
    logic        fall_flag;
    logic        rise_flag;
    logic        fall_seen;
    logic        rise_seen;
    logic        armed;
    logic [2:0]  sync1;
    logic [2:0]  sync2;
    logic        prev_below;
    logic        aw_got;
    logic [31:0] aw_addr;
    logic        w_got;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        wr_ctrl;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rd_ctrl;
  } lvc_state_t;

  localparam lvc_state_t LVC_ST_RST = '{
    ctrl:    LVC_CTRL_RST,
    default: '0
  };

  lvc_state_t st_r;
  lvc_state_t st_nxt;

  logic        aw_take;
  logic        w_take;
  logic        ar_take;
  logic        aw_has;
  logic        w_has;
  logic [31:0] aw_a;
  logic [31:0] w_d;
  logic [3:0]  w_s;
  logic        det_en;
  logic        below_fall;
  logic        above_rise;
  logic        below_reset;
  logic        fall_edge;

  // ----------------------------------------------------------------
  // Handshake outputs
  // ----------------------------------------------------------------
  // Readies drop with the clock enable so no beat is lost while frozen
  assign o_axil.awready = i_clk_en & ~st_r.aw_got & ~st_r.bvalid;
  assign o_axil.wready  = i_clk_en & ~st_r.w_got & ~st_r.bvalid;
  assign o_axil.arready = i_clk_en & ~st_r.rvalid;
  assign o_axil.bvalid  = st_r.bvalid;
  assign o_axil.bresp   = st_r.bresp;
  assign o_axil.rvalid  = st_r.rvalid;
  assign o_axil.rdata   = st_r.rdata;
  assign o_axil.rresp   = st_r.rresp;

  assign aw_take = i_axil.awvalid & o_axil.awready;
  assign w_take  = i_axil.wvalid & o_axil.wready;
  assign ar_take = i_axil.arvalid & o_axil.arready;
  assign aw_has  = st_r.aw_got | aw_take;
  assign w_has   = st_r.w_got | w_take;
  assign aw_a    = st_r.aw_got ? st_r.aw_addr : i_axil.awaddr;
  assign w_d     = st_r.w_got ? st_r.w_data : i_axil.wdata;
  assign w_s     = st_r.w_got ? st_r.w_strb : i_axil.wstrb;

  // ----------------------------------------------------------------
  // Control outputs
  // ----------------------------------------------------------------
  assign det_en = st_r.ctrl[LVC_DET_EN_BIT];
  assign o_ctrl.detector_enable           = det_en;
  assign o_ctrl.reference_enable          = st_r.ctrl[LVC_REF_EN_BIT];
  assign o_ctrl.internal_compare_select   = st_r.ctrl[LVC_INT_SEL_BIT];
  assign o_ctrl.reset_level_select        = st_r.ctrl[LVC_LVL_SEL_BIT];
  assign o_ctrl.undervoltage_reset_enable = st_r.ctrl[LVC_UVR_EN_BIT];
  assign o_ctrl.fall_irq_enable           = st_r.ctrl[LVC_FALL_EN_BIT];
  assign o_ctrl.rise_irq_enable           = st_r.ctrl[LVC_RISE_EN_BIT];

  // Comparator levels after the two-flop synchroniser
  assign below_fall  = st_r.sync2[2];
  assign above_rise  = st_r.sync2[1];
  assign below_reset = st_r.sync2[0];
  assign fall_edge   = below_fall & ~st_r.prev_below;

  // Reset request follows the level only while the detector is on
  assign o_uv_reset_req = det_en & st_r.ctrl[LVC_UVR_EN_BIT] & below_reset;

  assign o_irq = det_en &
                 ((st_r.fall_flag & st_r.ctrl[LVC_FALL_EN_BIT]) |
                  (st_r.rise_flag & st_r.ctrl[LVC_RISE_EN_BIT]));

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.sync1      = i_sense;
    st_nxt.sync2      = st_r.sync1;
    st_nxt.prev_below = below_fall;

    // Write address and data, taken in either order
    if (aw_take) begin
      st_nxt.aw_got  = 1'b1;
      st_nxt.aw_addr = i_axil.awaddr;
    end
    if (w_take) begin
      st_nxt.w_got  = 1'b1;
      st_nxt.w_data = i_axil.wdata;
      st_nxt.w_strb = i_axil.wstrb;
    end
    if (st_r.bvalid && i_axil.bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (aw_has && w_has) begin
      st_nxt.aw_got  = 1'b0;
      st_nxt.w_got   = 1'b0;
      st_nxt.w_data  = w_d;
      st_nxt.bvalid  = 1'b1;
      st_nxt.wr_ctrl = 1'b0;
      st_nxt.bresp   = LVC_OKAY;
      if (aw_a[31:2] == LVC_CTRL_OFS[31:2]) begin
        st_nxt.wr_ctrl = w_s[0];
        if (w_s[0]) begin
          st_nxt.ctrl = w_d[7:0] | LVC_CTRL_ONE;
        end
      end else if (aw_a[31:2] == LVC_STAT_OFS[31:2]) begin
        // Clear only a flag that software has already seen as 1
        if (w_s[0] && !w_d[LVC_FALL_FL_BIT] && st_r.fall_seen) begin
          st_nxt.fall_flag = 1'b0;
          st_nxt.fall_seen = 1'b0;
        end
        if (w_s[0] && !w_d[LVC_RISE_FL_BIT] && st_r.rise_seen) begin
          st_nxt.rise_flag = 1'b0;
          st_nxt.rise_seen = 1'b0;
        end
      end else begin
        st_nxt.bresp = LVC_SLVERR;
      end
    end

    // Read channel
    if (st_r.rvalid && i_axil.rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (ar_take) begin
      st_nxt.rvalid  = 1'b1;
      st_nxt.rresp   = LVC_OKAY;
      st_nxt.rd_ctrl = 1'b0;
      st_nxt.rdata   = '0;
      if (i_axil.araddr[31:2] == LVC_CTRL_OFS[31:2]) begin
        st_nxt.rd_ctrl     = 1'b1;
        st_nxt.rdata[7:0]  = st_r.ctrl | LVC_CTRL_ONE;
      end else if (i_axil.araddr[31:2] == LVC_STAT_OFS[31:2]) begin
        st_nxt.rdata[7:0] = {LVC_STAT_RSVD, st_r.fall_flag, st_r.rise_flag};
        // A read racing a clear must not arm the next clear
        st_nxt.fall_seen  = st_nxt.fall_seen | (st_r.fall_flag & st_nxt.fall_flag);
        st_nxt.rise_seen  = st_nxt.rise_seen | (st_r.rise_flag & st_nxt.rise_flag);
      end else begin
        st_nxt.rresp = LVC_SLVERR;
      end
    end

    // Detection events; applied after clears so a set wins
    if (det_en) begin
      if (fall_edge) begin
        st_nxt.fall_flag = 1'b1;
      end
      if (below_reset) begin
        st_nxt.armed = 1'b0;
      end else if (st_r.armed && above_rise) begin
        st_nxt.rise_flag = 1'b1;
        st_nxt.armed     = 1'b0;
      end else if (st_r.ctrl[LVC_RISE_EN_BIT] && below_fall) begin
        st_nxt.armed = 1'b1;
      end
    end else begin
      st_nxt.armed = 1'b0;
    end

    // Undervoltage reset keeps bits 7,6,5,3,2, reloads the rest from the reset value, clears the flags
    if (i_uv_reset) begin
      st_nxt.ctrl      = (st_r.ctrl & LVC_CTRL_KEEP) |
                         (LVC_CTRL_RST & ~LVC_CTRL_KEEP);
      st_nxt.fall_flag = 1'b0;
      st_nxt.rise_flag = 1'b0;
      st_nxt.fall_seen = 1'b0;
      st_nxt.rise_seen = 1'b0;
      st_nxt.armed     = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Power-on and watchdog reset arrive on i_rst_b and reset everything
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_r <= LVC_ST_RST;
    end else if (i_clk_en) begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_b);

  sequence s_ctrl_wr;
    $rose(st_r.bvalid) && st_r.wr_ctrl && !$past(i_uv_reset);
  endsequence

  property p_wr_bit(int b, logic q);
    s_ctrl_wr |-> q == st_r.w_data[b];
  endproperty

  AST_DET_EN_WR: assert property (p_wr_bit(7, o_ctrl.detector_enable))
    else $error("detector enable does not follow write");
  AST_REF_EN_WR: assert property (p_wr_bit(6, o_ctrl.reference_enable))
    else $error("reference enable does not follow write");
  AST_INT_SEL_WR: assert property (p_wr_bit(5, o_ctrl.internal_compare_select))
    else $error("compare select does not follow write");
  AST_LVL_SEL_WR: assert property (p_wr_bit(3, o_ctrl.reset_level_select))
    else $error("reset level select does not follow write");
  AST_UVR_EN_WR: assert property (p_wr_bit(2, o_ctrl.undervoltage_reset_enable))
    else $error("undervoltage reset enable does not follow write");
  AST_FALL_EN_WR: assert property (p_wr_bit(1, o_ctrl.fall_irq_enable))
    else $error("fall enable does not follow write");
  AST_RISE_EN_WR: assert property (p_wr_bit(0, o_ctrl.rise_irq_enable))
    else $error("rise enable does not follow write");

  AST_RSVD_ONE: assert property (
    o_axil.rvalid && st_r.rd_ctrl |-> o_axil.rdata[4] == 1'b1)
    else $error("reserved control bit read as 0");

  AST_UV_KEEP: assert property (
    i_uv_reset && i_clk_en |=>
      (st_r.ctrl & LVC_CTRL_KEEP) == ($past(st_r.ctrl) & LVC_CTRL_KEEP) &&
      st_r.ctrl[1:0] == 2'h0)
    else $error("undervoltage reset disturbed kept bits");

  AST_DIS_QUIET: assert property (
    !o_ctrl.detector_enable |-> !o_irq && !o_uv_reset_req)
    else $error("detector off but outputs active");

  sequence s_fall_seen;
    i_clk_en && det_en && fall_edge && !i_uv_reset;
  endsequence

  AST_FALL_SET: assert property (
    s_fall_seen |=> st_r.fall_flag)
    else $error("fall flag not set after supply drop");

  AST_RISE_SET: assert property (
    i_clk_en && det_en && st_r.armed && above_rise && !below_reset &&
    !i_uv_reset |=> st_r.rise_flag)
    else $error("rise flag not set after recovery");

  // Outside an undervoltage reset, a flag only drops after software has read it as 1
  AST_FALL_CLR: assert property (
    $fell(st_r.fall_flag) && !$past(i_uv_reset) |-> $past(st_r.fall_seen))
    else $error("fall flag cleared without a prior read");
  AST_RISE_CLR: assert property (
    $fell(st_r.rise_flag) && !$past(i_uv_reset) |-> $past(st_r.rise_seen))
    else $error("rise flag cleared without a prior read");

  AST_IRQ_FALL: assert property (
    $rose(st_r.fall_flag) && det_en && o_ctrl.fall_irq_enable |-> o_irq)
    else $error("fall event raised no interrupt");

endmodule // lvc_ctrl

/* File: test/lvc_sense_model.sv */
// Behavioural supply comparators on the far side of the sense inputs
`timescale 1ns/1ps
module lvc_sense_model
  import lvc_pkg::*;
#(
  parameter int FALL_MV   = 3700,
  parameter int RISE_MV   = 4000,
  parameter int RST_LO_MV = 2300,
  parameter int RST_HI_MV = 3600
) (
  input  wire logic [15:0] i_supply_mv,
  input  wire logic        i_lvl_high,
  output lvc_sense_t       o_sense
);
  // Ideal comparators: no hysteresis, so tests keep well clear of the levels
  always_comb begin
    o_sense.below_fall  = int'(i_supply_mv) < FALL_MV;
    o_sense.above_rise  = int'(i_supply_mv) > RISE_MV;
    o_sense.below_reset = int'(i_supply_mv) < (i_lvl_high ? RST_HI_MV : RST_LO_MV);
  end
endmodule // lvc_sense_model

/* File: test/testbench.sv */
// Self-checking bench for the low-voltage detect control block
`timescale 1ns/1ps
module testbench;
  import lvc_pkg::*;
  typedef struct packed {logic [7:0] wr; logic [31:0] rd; logic [6:0] ctl;} lvc_tb_row_t;
  logic          clk, rst_b, clk_en, uv_reset, lvl_high;
  logic [15:0]   supply;
  lvc_sense_t    sense;
  lvc_axil_req_t req;
  lvc_axil_rsp_t rsp;
  lvc_ctrl_out_t ctrl;
  logic          uv_req, irq;
  logic [31:0]   rd;
  logic [1:0]    resp;
  int            num_errors, n_checks;
  lvc_tb_row_t   rows [4] = '{'{8'h00, 32'h10, 7'h00}, '{8'hFF, 32'hFF, 7'h7F},
                              '{8'hA5, 32'hB5, 7'h55}, '{8'h4A, 32'h5A, 7'h2A}};

  lvc_sense_model model (.i_supply_mv(supply), .i_lvl_high(ctrl.reset_level_select),
                         .o_sense(sense));
  lvc_ctrl uut (.i_core_clk(clk), .i_rst_b(rst_b), .i_clk_en(clk_en), .i_uv_reset(uv_reset),
                .i_sense(sense), .i_axil(req), .o_axil(rsp), .o_ctrl(ctrl),
                .o_uv_reset_req(uv_req), .o_irq(irq));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // ----------------------------------------------------------------
  // Bus master: releases each channel at the edge it is taken
  // ----------------------------------------------------------------
  task automatic axw(input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= d;
    req.wstrb   <= 4'hF;
    req.bready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid === 1'b1) begin
        resp = rsp.bresp;
        req.bready <= 1'b0;
        break;
      end
    end
    if (n == 50) begin
      num_errors++;
      give_verdict();
    end
  endtask

  task automatic axr(input logic [31:0] a);
    int n;
    @(posedge clk);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid === 1'b1) begin
        rd   = rsp.rdata;
        resp = rsp.rresp;
        req.rready <= 1'b0;
        break;
      end
    end
    if (n == 50) begin
      num_errors++;
      give_verdict();
    end
  endtask

  task automatic sense_step(input logic [15:0] mv);
    supply <= mv;
    repeat (6) @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_b = 1'b0; clk_en = 1'b1; uv_reset = 1'b0; supply = 16'h1388; req = '0;
    num_errors = 0; n_checks = 0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    axr(LVC_CTRL_OFS); check(rd, 32'hF4);
    check({25'h0, ctrl}, 32'h74);
    axr(LVC_STAT_OFS); check(rd, 32'hFC);
    foreach (rows[i]) begin
      axw(LVC_CTRL_OFS, {24'h0, rows[i].wr});
      axr(LVC_CTRL_OFS); check(rd, rows[i].rd);
      check({29'h0, ctrl[6:4]}, {29'h0, rows[i].ctl[6:4]});
      check({28'h0, ctrl[3:0]}, {28'h0, rows[i].ctl[3:0]});
    end
    axr(32'h0000_0008); check(rd, 32'h0);
    check({30'h0, resp}, {30'h0, LVC_SLVERR});
    axw(32'h0000_0008, 32'h0); check({30'h0, resp}, {30'h0, LVC_SLVERR});
    // Undervoltage reset keeps bits 7,6,5,3,2 only
    axw(LVC_CTRL_OFS, 32'hEF); check({30'h0, resp}, {30'h0, LVC_OKAY});
    uv_reset <= 1'b1;
    @(posedge clk);
    uv_reset <= 1'b0;
    axr(LVC_CTRL_OFS); check(rd, 32'hFC);
    // Low reset level while interrupts are in use
    axw(LVC_CTRL_OFS, 32'hE6);
    sense_step(16'h0DAC);
    check({irq, uv_req}, 2'b10);
    sense_step(16'h1388);
    axw(LVC_STAT_OFS, 32'h0);
    axr(LVC_STAT_OFS); check(rd, 32'hFE);
    axw(LVC_STAT_OFS, 32'h0);
    axr(LVC_STAT_OFS); check(rd, 32'hFC);
    check(irq, 1'b0);
    // Fall, then recovery above the rise level
    axw(LVC_CTRL_OFS, 32'hE5);
    sense_step(16'h0DAC);
    check(irq, 1'b0);
    sense_step(16'h1004);
    check(irq, 1'b1);
    axr(LVC_STAT_OFS); check(rd, 32'hFF);
    axw(LVC_STAT_OFS, 32'h0);
    axr(LVC_STAT_OFS); check(rd, 32'hFC);
    // Reaching the reset level disarms the rise flag
    sense_step(16'h0DAC);
    sense_step(16'h07D0);
    check(uv_req, 1'b1);
    sense_step(16'h1004);
    check(uv_req, 1'b0);
    axr(LVC_STAT_OFS); check(rd, 32'hFE);
    axw(LVC_STAT_OFS, 32'h0);
    // Detector off: other settings ignored
    axw(LVC_CTRL_OFS, 32'h67);
    sense_step(16'h07D0);
    check({irq, uv_req}, 2'b00);
    axr(LVC_STAT_OFS); check(rd, 32'hFC);
    sense_step(16'h1388);
    // Clock enable low refuses the bus and freezes state
    @(posedge clk);
    clk_en   <= 1'b0;
    uv_reset <= 1'b1;
    @(posedge clk);
    check(rsp.awready, 1'b0);
    uv_reset <= 1'b0;
    @(posedge clk);
    clk_en <= 1'b1;
    check({25'h0, ctrl}, 32'h37);
    // Power-on reset in mid-run restores the control reset value F4
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    axr(LVC_CTRL_OFS); check(rd, 32'hF4);
    give_verdict();
  end
endmodule // testbench
